/* File: core/iac_pkg.sv */
package iac_pkg;
  // Register byte addresses, low byte at the even address
  localparam logic [5:0] IAC_ADDR_INCL_360 = 6'h0c;
  localparam logic [5:0] IAC_ADDR_INCL_SIGNED = 6'h0e;
  localparam logic [5:0] IAC_ADDR_TRIM = 6'h18;
  localparam logic [5:0] IAC_ADDR_LIM1 = 6'h20;
  localparam logic [5:0] IAC_ADDR_LIM2 = 6'h22;
  localparam logic [5:0] IAC_ADDR_WIN1 = 6'h24;
  localparam logic [5:0] IAC_ADDR_WIN2 = 6'h26;
  localparam logic [5:0] IAC_ADDR_CTRL = 6'h28;

  // Writable bit masks; unused bits hold and read zero
  localparam logic [15:0] IAC_MASK_TRIM = 16'h3fff;
  localparam logic [15:0] IAC_MASK_LIM = 16'hbfff;
  localparam logic [15:0] IAC_MASK_WIN = 16'h00ff;
  localparam logic [15:0] IAC_MASK_CTRL = 16'hff37;
  localparam logic [15:0] IAC_REG_RESET = 16'h0000;

  // Limit register fields
  localparam int IAC_LIM_ABOVE_BIT = 15;
  localparam int IAC_LIM_MSB = 13;

  // Alarm control fields
  localparam int IAC_CTRL_PIN_SEL_BIT = 0;
  localparam int IAC_CTRL_POL_BIT = 1;
  localparam int IAC_CTRL_OUT_EN_BIT = 2;
  localparam int IAC_CTRL_FILT1_BIT = 4;
  localparam int IAC_CTRL_FILT2_BIT = 5;
  localparam int IAC_CTRL_SRC1_LSB = 8;
  localparam int IAC_CTRL_SLOPE1_BIT = 11;
  localparam int IAC_CTRL_SRC2_LSB = 12;
  localparam int IAC_CTRL_SLOPE2_BIT = 15;

  typedef enum logic [2:0] {
    IAC_SRC_OFF = 3'b000,
    IAC_SRC_SUPPLY = 3'b001,
    IAC_SRC_UNUSED2 = 3'b010,
    IAC_SRC_UNUSED3 = 3'b011,
    IAC_SRC_AUX = 3'b100,
    IAC_SRC_TEMP = 3'b101,
    IAC_SRC_INCL_360 = 3'b110,
    IAC_SRC_INCL_SIGNED = 3'b111
  } iac_src_t;

  // One full turn in 0.025 degree counts, and the half turn
  localparam logic [14:0] IAC_FULL_TURN = 15'h3840;
  localparam logic [14:0] IAC_HALF_TURN = 15'h1c20;
endpackage

/* File: core/iac_alarm_chan.sv */
`timescale 1ns/10ps
module iac_alarm_chan
  import iac_pkg::*;
#(
  parameter int WW = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Sample stream
  input wire logic sample_tick,
  input wire logic [13:0] value,
  input wire logic value_signed,
  // Settings
  input wire logic src_on,
  input wire logic slope_mode,
  input wire logic above,
  input wire logic [13:0] limit,
  input wire logic [WW-1:0] window,
  // Result
  output logic active
);
  logic [13:0] base_r;
  logic [WW-1:0] cnt_r;
  logic run_r;
  logic active_r;

  wire logic [14:0] val_ext = value_signed ? {value[13], value} : {1'b0, value};
  wire logic [14:0] lim_ext = value_signed ? {limit[13], limit} : {1'b0, limit};
  wire logic [14:0] base_ext = value_signed ? {base_r[13], base_r} : {1'b0, base_r};
  wire logic level_hit = above ? ($signed(val_ext) > $signed(lim_ext))
                               : ($signed(val_ext) < $signed(lim_ext));
  // Zero window behaves as one sample
  wire logic [WW-1:0] win_n = (window == '0) ? WW'(1) : window;
  wire logic [WW-1:0] cnt_nxt = cnt_r + WW'(1);
  wire logic signed [15:0] delta = $signed({val_ext[14], val_ext}) - $signed({base_ext[14], base_ext});
  // Compare the total change with limit times window instead of dividing
  // Limit takes the source's format, so an unsigned limit is never read as negative
  wire logic signed [WW+15:0] scaled = (WW+16)'($signed(lim_ext)) * (WW+16)'($signed({1'b0, win_n}));
  wire logic signed [WW+15:0] delta_ext = (WW+16)'(delta);
  wire logic slope_hit = above ? (delta_ext > scaled) : (delta_ext < scaled);
  wire logic win_done = run_r && (cnt_nxt == win_n);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      base_r <= '0;
      cnt_r <= '0;
      run_r <= 1'b0;
      active_r <= 1'b0;
    end else if (!src_on) begin
      run_r <= 1'b0;
      active_r <= 1'b0;
    end else if (sample_tick) begin
      if (!slope_mode) begin
        active_r <= level_hit;
        run_r <= 1'b0;
      end else if (!run_r || win_done) begin
        base_r <= value;
        cnt_r <= '0;
        run_r <= 1'b1;
        if (win_done) begin
          active_r <= slope_hit;
        end
      end else begin
        cnt_r <= cnt_nxt;
      end
    end
  end

  assign active = active_r;
endmodule

/* File: core/iac_core.sv */
`timescale 1ns/10ps
module iac_core
  import iac_pkg::*;
#(
  parameter int WW = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port, byte wide
  input wire logic [5:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Nonvolatile image
  input wire logic nv_load,
  input wire logic [95:0] nv_image,
  output logic [95:0] nv_image_out,
  // Sample stream from the data path
  input wire logic sample_tick,
  input wire logic [11:0] inst_supply,
  input wire logic [11:0] filt_supply,
  input wire logic [11:0] inst_aux,
  input wire logic [11:0] filt_aux,
  input wire logic [11:0] inst_temp,
  input wire logic [11:0] filt_temp,
  input wire logic [13:0] inst_incline,
  input wire logic [13:0] filt_incline,
  // Incline results and alarm state
  output logic [13:0] incline_360_result,
  output logic [13:0] incline_signed_result,
  output logic [1:0] alarm_status,
  // Pin claims from other control registers
  input wire logic [1:0] misc_pin_claim,
  input wire logic [1:0] misc_pin_value,
  input wire logic [1:0] gpio_pin_dir_out,
  input wire logic [1:0] gpio_pin_value,
  // Auxiliary pins, index 0 first, 1 second
  input wire logic [1:0] aux_pin_in,
  output logic [1:0] aux_pin_out,
  output logic [1:0] aux_pin_oe_n,
  output logic [1:0] aux_pin_level
);
  logic [15:0] trim_r;
  logic [15:0] lim_r [2];
  logic [15:0] win_r [2];
  logic [15:0] ctrl_r;
  logic [13:0] incl_360_r;
  logic [13:0] incl_signed_r;
  logic [7:0] rdata_r;
  logic [1:0] pin_out_r;
  logic [1:0] pin_oe_n_r;
  logic [1:0] pin_meta_r;
  logic [1:0] pin_sync_r;
  wire logic [1:0] chan_active;

  // Byte write into a 16-bit register; odd address is the upper byte
  function automatic logic [15:0] byte_merge(input logic [15:0] old, input logic hi,
                                              input logic [7:0] d, input logic [15:0] mask);
    logic [15:0] m;
    m = hi ? {d, old[7:0]} : {old[15:8], d};
    byte_merge = m & mask;
  endfunction

  // Trimmed 0..360 result, wrapped at one full turn
  function automatic logic [13:0] trim_360(input logic [13:0] raw, input logic [13:0] trim);
    logic [14:0] s;
    s = {1'b0, raw} + {1'b0, trim};
    if (s >= IAC_FULL_TURN) begin
      s = s - IAC_FULL_TURN;
    end
    trim_360 = s[13:0];
  endfunction

  // Upper half turn maps to negative angles
  function automatic logic [13:0] to_signed(input logic [13:0] a);
    logic [14:0] s;
    s = {1'b0, a};
    if (s >= IAC_HALF_TURN) begin
      s = s - IAC_FULL_TURN;
    end
    to_signed = s[13:0];
  endfunction

  wire logic [13:0] trim_val = trim_r[13:0];
  wire logic [13:0] inst_360 = trim_360(inst_incline, trim_val);
  wire logic [13:0] filt_360 = trim_360(filt_incline, trim_val);
  wire logic [13:0] inst_sgn = to_signed(inst_360);
  wire logic [13:0] filt_sgn = to_signed(filt_360);

  // Source picker, shared by both channels
  function automatic logic [13:0] pick_src(input logic [2:0] code, input logic filt,
                                            input logic [11:0] is, input logic [11:0] fs,
                                            input logic [11:0] ia, input logic [11:0] fa,
                                            input logic [11:0] it, input logic [11:0] ft,
                                            input logic [13:0] i3, input logic [13:0] f3,
                                            input logic [13:0] ig, input logic [13:0] fg);
    case (code)
      IAC_SRC_SUPPLY: pick_src = {2'b00, filt ? fs : is};
      IAC_SRC_AUX: pick_src = {2'b00, filt ? fa : ia};
      IAC_SRC_TEMP: pick_src = {2'b00, filt ? ft : it};
      IAC_SRC_INCL_360: pick_src = filt ? f3 : i3;
      IAC_SRC_INCL_SIGNED: pick_src = filt ? fg : ig;
      default: pick_src = 14'h0000;
    endcase
  endfunction

  // Unused codes count as disabled
  function automatic logic src_valid(input logic [2:0] code);
    src_valid = (code != IAC_SRC_OFF) && (code != IAC_SRC_UNUSED2) && (code != IAC_SRC_UNUSED3);
  endfunction

  wire logic [2:0] src_code [2];
  wire logic filt_sel [2];
  wire logic slope_sel [2];
  assign src_code[0] = ctrl_r[IAC_CTRL_SRC1_LSB+2:IAC_CTRL_SRC1_LSB];
  assign src_code[1] = ctrl_r[IAC_CTRL_SRC2_LSB+2:IAC_CTRL_SRC2_LSB];
  assign filt_sel[0] = ctrl_r[IAC_CTRL_FILT1_BIT];
  assign filt_sel[1] = ctrl_r[IAC_CTRL_FILT2_BIT];
  assign slope_sel[0] = ctrl_r[IAC_CTRL_SLOPE1_BIT];
  assign slope_sel[1] = ctrl_r[IAC_CTRL_SLOPE2_BIT];

  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_chan
      wire logic [13:0] chan_val = pick_src(src_code[c], filt_sel[c], inst_supply, filt_supply,
                                            inst_aux, filt_aux, inst_temp, filt_temp,
                                            inst_360, filt_360, inst_sgn, filt_sgn);
      iac_alarm_chan #(.WW(WW)) u_chan (
        .mclk(mclk),
        .rst_n(rst_n),
        .sample_tick(sample_tick),
        .value(chan_val),
        .value_signed(src_code[c] == IAC_SRC_INCL_SIGNED),
        .src_on(src_valid(src_code[c])),
        .slope_mode(slope_sel[c]),
        .above(lim_r[c][IAC_LIM_ABOVE_BIT]),
        .limit(lim_r[c][IAC_LIM_MSB:0]),
        .window(win_r[c][WW-1:0]),
        .active(chan_active[c])
      );
    end
  endgenerate

  // Shared alarm line; while disabled it claims no pin and its level sits inactive
  wire logic out_en = ctrl_r[IAC_CTRL_OUT_EN_BIT];
  wire logic out_pol = ctrl_r[IAC_CTRL_POL_BIT];
  wire logic any_alarm = |chan_active;
  wire logic alarm_level = out_en ? (any_alarm ~^ out_pol) : ~out_pol;
  wire logic [1:0] alarm_claim = out_en ? (ctrl_r[IAC_CTRL_PIN_SEL_BIT] ? 2'b10 : 2'b01) : 2'b00;

  wire logic [1:0] pin_drive;
  wire logic [1:0] pin_level;

  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_pin
      assign pin_drive[p] = misc_pin_claim[p] | alarm_claim[p] | gpio_pin_dir_out[p];
      assign pin_level[p] = misc_pin_claim[p] ? misc_pin_value[p] :
                            alarm_claim[p] ? alarm_level :
                            gpio_pin_value[p];
    end
  endgenerate

  // One process owns both pin registers, so no bit has two writers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out_r <= '0;
      pin_oe_n_r <= '1;
    end else begin
      pin_out_r <= pin_level;
      pin_oe_n_r <= ~pin_drive;
    end
  end

  // Register writes
  wire logic wr_hi = reg_addr[0];
  wire logic [5:0] wr_word = {reg_addr[5:1], 1'b0};

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      trim_r <= IAC_REG_RESET;
      lim_r[0] <= IAC_REG_RESET;
      lim_r[1] <= IAC_REG_RESET;
      win_r[0] <= IAC_REG_RESET;
      win_r[1] <= IAC_REG_RESET;
      ctrl_r <= IAC_REG_RESET;
    end else if (nv_load) begin
      trim_r <= nv_image[15:0] & IAC_MASK_TRIM;
      lim_r[0] <= nv_image[31:16] & IAC_MASK_LIM;
      lim_r[1] <= nv_image[47:32] & IAC_MASK_LIM;
      win_r[0] <= nv_image[63:48] & IAC_MASK_WIN;
      win_r[1] <= nv_image[79:64] & IAC_MASK_WIN;
      ctrl_r <= nv_image[95:80] & IAC_MASK_CTRL;
    end else if (reg_wr) begin
      case (wr_word)
        IAC_ADDR_TRIM: trim_r <= byte_merge(trim_r, wr_hi, reg_wdata, IAC_MASK_TRIM);
        IAC_ADDR_LIM1: lim_r[0] <= byte_merge(lim_r[0], wr_hi, reg_wdata, IAC_MASK_LIM);
        IAC_ADDR_LIM2: lim_r[1] <= byte_merge(lim_r[1], wr_hi, reg_wdata, IAC_MASK_LIM);
        IAC_ADDR_WIN1: win_r[0] <= byte_merge(win_r[0], wr_hi, reg_wdata, IAC_MASK_WIN);
        IAC_ADDR_WIN2: win_r[1] <= byte_merge(win_r[1], wr_hi, reg_wdata, IAC_MASK_WIN);
        IAC_ADDR_CTRL: ctrl_r <= byte_merge(ctrl_r, wr_hi, reg_wdata, IAC_MASK_CTRL);
        default: ;
      endcase
    end
  end

  // Results follow the filtered incline, refreshed once per sample
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      incl_360_r <= '0;
      incl_signed_r <= '0;
    end else if (sample_tick) begin
      incl_360_r <= filt_360;
      incl_signed_r <= filt_sgn;
    end
  end

  // Register reads; unmapped addresses read zero
  logic [15:0] rd_word;
  always_comb begin
    case (wr_word)
      IAC_ADDR_INCL_360: rd_word = {2'b00, incl_360_r};
      IAC_ADDR_INCL_SIGNED: rd_word = {2'b00, incl_signed_r};
      IAC_ADDR_TRIM: rd_word = trim_r;
      IAC_ADDR_LIM1: rd_word = lim_r[0];
      IAC_ADDR_LIM2: rd_word = lim_r[1];
      IAC_ADDR_WIN1: rd_word = win_r[0];
      IAC_ADDR_WIN2: rd_word = win_r[1];
      IAC_ADDR_CTRL: rd_word = ctrl_r;
      default: rd_word = 16'h0000;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= '0;
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end else begin
      if (reg_rd) begin
        rdata_r <= wr_hi ? rd_word[15:8] : rd_word[7:0];
      end
      pin_meta_r <= aux_pin_in;
      pin_sync_r <= pin_meta_r;
    end
  end

  assign reg_rdata = rdata_r;
  assign nv_image_out = {ctrl_r, win_r[1], win_r[0], lim_r[1], lim_r[0], trim_r};
  assign incline_360_result = incl_360_r;
  assign incline_signed_result = incl_signed_r;
  assign alarm_status = chan_active;
  assign aux_pin_out = pin_out_r;
  assign aux_pin_oe_n = pin_oe_n_r;
  assign aux_pin_level = pin_sync_r;
endmodule

/* File: bench/iac_core_chk.sv */
`timescale 1ns/10ps
module iac_core_chk
  import iac_pkg::*;
#(
  parameter int WW = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire logic [5:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic nv_load,
  input wire logic [95:0] nv_image,
  // Alarm and pins
  input wire logic sample_tick,
  input wire logic [1:0] alarm_status,
  input wire logic [1:0] misc_pin_claim,
  input wire logic [1:0] misc_pin_value,
  input wire logic [1:0] gpio_pin_dir_out,
  input wire logic [1:0] gpio_pin_value,
  input wire logic [1:0] aux_pin_out,
  input wire logic [1:0] aux_pin_oe_n
);
  // Control shadow rebuilt from port traffic, since the register itself is hidden
  logic [15:0] ctrl_r;
  logic [15:0] ctrl_nxt;
  wire lo_wr = reg_wr && reg_addr == IAC_ADDR_CTRL;
  wire hi_wr = reg_wr && reg_addr == 6'h29;
  assign ctrl_nxt = nv_load ? (nv_image[95:80] & 16'hff37) :
    {hi_wr ? reg_wdata : ctrl_r[15:8], lo_wr ? (reg_wdata & 8'h37) : ctrl_r[7:0]};
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= 16'h0000;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end
  wire off1 = ctrl_r[10:8] == 3'b000 || ctrl_r[10:9] == 2'b01;
  wire off2 = ctrl_r[14:12] == 3'b000 || ctrl_r[14:13] == 2'b01;
  wire pin0_alarm = ctrl_r[2] && !ctrl_r[0];
  wire pin1_alarm = ctrl_r[2] && ctrl_r[0];
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence ctrl_quiet;
    $stable(ctrl_r) ##1 $stable(ctrl_r);
  endsequence
  a_one_off: assert property (off1 [*3] |-> !alarm_status[0])
    else $error("ch1 active while off");
  a_two_off: assert property (off2 [*3] |-> !alarm_status[1])
    else $error("ch2 active while off");
  a_status_holds: assert property (ctrl_quiet ##0 !sample_tick |=> $stable(alarm_status))
    else $error("status moved without tick");
  a_misc_wins: assert property (misc_pin_claim[1] |=>
    !aux_pin_oe_n[1] && aux_pin_out[1] == $past(misc_pin_value[1])) else $error("misc claim lost");
  a_alarm_drives: assert property (!misc_pin_claim[1] && pin1_alarm |=> !aux_pin_oe_n[1] &&
    aux_pin_out[1] == ($past(ctrl_r[1]) == (|$past(alarm_status)))) else $error("alarm pin wrong");
  a_gpio_last: assert property (!misc_pin_claim[0] && !pin0_alarm && gpio_pin_dir_out[0] |=>
    !aux_pin_oe_n[0] && aux_pin_out[0] == $past(gpio_pin_value[0])) else $error("gpio drive lost");
  a_pin_freed: assert property (!misc_pin_claim[0] && !pin0_alarm && !gpio_pin_dir_out[0] |=>
    aux_pin_oe_n[0]) else $error("pin driven unclaimed");
  a_window_top_zero: assert property (reg_rd && (reg_addr == 6'h25 || reg_addr == 6'h27) |=>
    reg_rdata == 8'h00) else $error("window top not zero");
endmodule
bind iac_core iac_core_chk #(.WW(WW)) u_chk (.mclk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
  .reg_rdata, .nv_load, .nv_image, .sample_tick, .alarm_status, .misc_pin_claim, .misc_pin_value,
  .gpio_pin_dir_out, .gpio_pin_value, .aux_pin_out, .aux_pin_oe_n);

/* File: bench/iac_host.sv */
`timescale 1ns/10ps
module iac_host (
  // Clock
  input wire logic mclk,
  // Register port
  output logic [5:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
  end
  // Low byte first; idle lines show the inverse of their last value
  task automatic wr16(input logic [5:0] a, input logic [15:0] d);
    @(negedge mclk);
    {reg_addr, reg_wdata, reg_wr} = {a, d[7:0], 1'b1};
    @(negedge mclk);
    {reg_addr, reg_wdata} = {a + 6'h01, d[15:8]};
    @(negedge mclk);
    {reg_addr, reg_wdata, reg_wr} = {~reg_addr, ~reg_wdata, 1'b0};
  endtask
  task automatic rd16(input logic [5:0] a, output logic [15:0] d);
    @(negedge mclk);
    {reg_addr, reg_rd} = {a, 1'b1};
    @(negedge mclk);
    d[7:0] = reg_rdata;
    reg_addr = a + 6'h01;
    @(negedge mclk);
    d[15:8] = reg_rdata;
    {reg_addr, reg_rd} = {~reg_addr, 1'b0};
  endtask
endmodule

/* File: bench/testbench.sv */
`timescale 1ns/10ps
module testbench;
  import iac_pkg::*;
  logic mclk, rst_n, reg_wr, reg_rd, nv_load, sample_tick;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [95:0] nv_image, nv_image_out;
  logic [11:0] d12;
  logic [13:0] inst_incline, filt_incline, incline_360_result, incline_signed_result;
  logic [1:0] alarm_status, misc_pin_claim, misc_pin_value, gpio_pin_dir_out, gpio_pin_value;
  logic [1:0] ext, aux_pin_in, aux_pin_out, aux_pin_oe_n, aux_pin_level;
  int miscompares, checks_done;
  logic [5:0] ra [6] = '{IAC_ADDR_TRIM, IAC_ADDR_LIM1, IAC_ADDR_LIM2, IAC_ADDR_WIN1, IAC_ADDR_WIN2, IAC_ADDR_CTRL};
  logic [15:0] rm [6] = '{16'h381f, 16'hbfff, 16'hbfff, 16'h00ff, 16'h00ff, 16'hff37};
  logic [15:0] lc [7] = '{16'h0617, 16'h0607, 16'h0607, 16'h0605, 16'h0604, 16'h0600, 16'h0000};
  logic [15:0] ll [7] = '{16'h8010, 16'h8010, 16'h0010, 16'h0010, 16'h0010, 16'h0010, 16'h0010};
  logic [15:0] le [7] = '{16'h25, 16'h04, 16'h25, 16'h05, 16'h09, 16'h0d, 16'h0c};
  // Pin follows the core where it drives, else the pulled-up far end
  assign aux_pin_in = (~aux_pin_oe_n & aux_pin_out) | (aux_pin_oe_n & ext);
  iac_host u_host (.mclk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata);
  iac_core #(.WW(8)) u_dut (.mclk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
    .nv_load, .nv_image, .nv_image_out, .sample_tick, .inst_supply(d12), .filt_supply(d12),
    .inst_aux(d12), .filt_aux(d12), .inst_temp(d12), .filt_temp(d12), .inst_incline, .filt_incline,
    .incline_360_result, .incline_signed_result, .alarm_status, .misc_pin_claim, .misc_pin_value,
    .gpio_pin_dir_out, .gpio_pin_value, .aux_pin_in, .aux_pin_out, .aux_pin_oe_n, .aux_pin_level);
  function automatic logic [15:0] st();
    return {10'h000, aux_pin_out & ~aux_pin_oe_n, aux_pin_oe_n, alarm_status};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [5:0] a, input logic [15:0] exp);
    logic [15:0] d;
    u_host.rd16(a, d);
    chk(d, exp);
  endtask
  task automatic tick();
    @(negedge mclk);
    sample_tick = 1'b1;
    @(negedge mclk);
    sample_tick = 1'b0;
    @(negedge mclk);
  endtask
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    #1000000;
    miscompares++;
    end_of_test();
  end
  initial begin
    {rst_n, nv_load, sample_tick, misc_pin_claim, misc_pin_value, gpio_pin_dir_out, gpio_pin_value} = '0;
    {nv_image, inst_incline, filt_incline, miscompares, checks_done} = '0;
    d12 = 12'h100;
    ext = 2'b11;
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    foreach (ra[i]) rchk(ra[i], 16'h0000);
    foreach (ra[i]) begin
      u_host.wr16(ra[i], (i == 0) ? rm[0] : 16'hffff);
      rchk(ra[i], rm[i]);
    end
    rchk(6'h2a, 16'h0000);
    $display("test registers done");
    u_host.wr16(IAC_ADDR_CTRL, 16'h0000);
    u_host.wr16(IAC_ADDR_TRIM, 16'd100);
    filt_incline = 14'd14350;
    tick();
    chk({2'b00, incline_360_result}, 16'd50);
    chk({2'b00, incline_signed_result}, 16'd50);
    u_host.wr16(IAC_ADDR_TRIM, 16'd0);
    filt_incline = 14'd10000;
    tick();
    chk({2'b00, incline_360_result}, 16'd10000);
    chk({2'b00, incline_signed_result}, 16'h2ed0);
    $display("test trim done");
    filt_incline = 14'h0020;
    inst_incline = 14'h0005;
    foreach (lc[i]) begin
      u_host.wr16(IAC_ADDR_LIM1, ll[i]);
      u_host.wr16(IAC_ADDR_CTRL, lc[i]);
      tick();
      chk(st(), le[i]);
    end
    $display("test level done");
    u_host.wr16(IAC_ADDR_LIM2, 16'h8010);
    for (int c = 0; c < 10; c++) begin
      filt_incline = (c < 8) ? 14'h0020 : 14'd14000;
      u_host.wr16(IAC_ADDR_CTRL, {1'b0, (c < 8) ? 3'(c) : 3'(c - 2), 12'h020});
      tick();
      chk(st(), (c == 8 || (c < 8 && c inside {1, 4, 5, 6, 7})) ? 16'h0e : 16'h0c);
    end
    $display("test sources done");
    u_host.wr16(IAC_ADDR_LIM1, 16'h8010);
    u_host.wr16(IAC_ADDR_CTRL, 16'h0617);
    tick();
    gpio_pin_dir_out = 2'b11;
    repeat (2) @(negedge mclk);
    chk(st(), 16'h21);
    misc_pin_claim = 2'b10;
    gpio_pin_value = 2'b01;
    repeat (2) @(negedge mclk);
    chk(st(), 16'h11);
    repeat (3) @(negedge mclk);
    chk({14'h0, aux_pin_level}, 16'h0001);
    {misc_pin_claim, gpio_pin_dir_out} = '0;
    $display("test pins done");
    u_host.wr16(IAC_ADDR_LIM1, 16'h8005);
    u_host.wr16(IAC_ADDR_LIM2, 16'h8005);
    u_host.wr16(IAC_ADDR_WIN1, 16'h0002);
    u_host.wr16(IAC_ADDR_WIN2, 16'h0003);
    u_host.wr16(IAC_ADDR_CTRL, 16'hee30);
    filt_incline = 14'd100;
    repeat (8) begin
      filt_incline = filt_incline + 14'd20;
      tick();
    end
    chk({14'h0, alarm_status}, 16'h0003);
    // A held value would still trip a level compare, so this separates the modes
    repeat (8) tick();
    chk({14'h0, alarm_status}, 16'h0000);
    $display("test slope done");
    nv_image = {16'hffff, 16'h0000, 16'h00aa, 16'h0000, 16'hc012, 16'h0123};
    @(negedge mclk);
    nv_load = 1'b1;
    @(negedge mclk);
    nv_load = 1'b0;
    rchk(IAC_ADDR_TRIM, 16'h0123);
    rchk(IAC_ADDR_LIM1, 16'h8012);
    rchk(IAC_ADDR_CTRL, 16'hff37);
    chk(nv_image_out[63:48], 16'h00aa);
    $display("test restore done");
    // Reset in mid-run must drop the restored settings and the alarm state
    rst_n = 1'b0;
    @(negedge mclk);
    rst_n = 1'b1;
    chk(st(), 16'h000c);
    rchk(IAC_ADDR_LIM1, 16'h0000);
    $display("test reset done");
    end_of_test();
  end
endmodule
